// ### hw/byte_store.sv
/*
 * Flip-flop byte store with one write port and two combinational
 * read ports. Assumes writer and readers share sys_clk.
 */
`timescale 1ns/1ps

module byte_store #(
   parameter int DEPTH = 256,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          sys_clk,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   input  wire logic [AW-1:0] rd_addr_a,
   output logic      [7:0]    rd_data_a,
   input  wire logic [AW-1:0] rd_addr_b,
   output logic      [7:0]    rd_data_b
);

   logic [7:0] mem [DEPTH];

   // Storage has no reset: contents are undefined until written
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Combinational reads so a read-modify-write fits in one cycle
   assign rd_data_a = mem[rd_addr_a];
   assign rd_data_b = mem[rd_addr_b];

endmodule

// ### hw/data_memory_map.sv
/*
 * Data memory addressing: internal RAM with bank, bit and upper-area
 * decode, external RAM, dual data pointer. Assumes the execution logic
 * drives requests on sys_clk, reads the index register itself for
 * indirect internal moves and answers forwarded reads in the same cycle.
 */
`timescale 1ns/1ps

// Summary of operation
// - Internal data RAM holds 256 bytes at one-byte addresses 0x00-0xFF.
// - Internal addresses are one byte; direct and indirect modes exist.
// - Direct access to 0x80-0xFF reaches only the SFRs.
// - Indirect access to 0x80-0xFF reaches a separate 128-byte RAM.
// - Lower 128 bytes are the same storage for direct and indirect use.
// - Bytes 0x00-0x1F are four banks of eight, bank n at 8n to 8n+7.
// - Two status word bits pick the bank used by bank register operands.
// - Bit addresses 0x00-0x7F map onto the bits of bytes 0x20-0x2F.
// - External space decodes 64KB; only 0x0000-0x07FF holds RAM.
// - External moves store from or load to the accumulator by Ri or pointer.
// - The Ri form uses index register 0 or 1 as an 8-bit address.
// - The pointer form uses the active pointer as a 16-bit address.
// - Two 16-bit data pointers exist, primary and secondary.
// - Bit 0 of the pointer select register picks the active pointer.
// - Every pointer instruction acts on the currently selected pointer.
module data_memory_map
   import mem_map_pkg::*;
#(
   parameter int EXTERNAL_DATA_RAM_DEPTH = EXTERNAL_DATA_RAM_BYTES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [1:0]  psw_bank,
   input  wire int_req_t    int_req,
   output logic      [7:0]  int_rdata,
   output logic             int_rvalid,
   input  wire bit_req_t    bit_req,
   output logic             bit_rdata,
   output logic             bit_rvalid,
   input  wire xmove_req_t  xmove,
   output logic      [7:0]  x_rdata,
   output logic             x_rvalid,
   input  wire ptr_cmd_t    ptr_cmd,
   output logic      [15:0] active_pointer,
   output bus_req_t         sfr_req,
   input  wire logic [7:0]  sfr_rdata,
   output bus_req_t         periph_req,
   input  wire logic [7:0]  periph_rdata
);

   localparam int XAW = $clog2(EXTERNAL_DATA_RAM_DEPTH);
   // ********************************************************************
   // Pointer state
   // ********************************************************************
   logic [15:0] primary_data_pointer;
   logic [15:0] secondary_data_pointer;
   logic        pointer_select;
   assign active_pointer = pointer_select ? secondary_data_pointer
                                          : primary_data_pointer;

   // ********************************************************************
   // Internal address decode
   // ********************************************************************
   logic       direct_upper;
   logic       local_sfr;
   logic [7:0] internal_data_ram_addr_a;
   logic [7:0] internal_data_ram_addr_b;
   logic [7:0] internal_data_ram_rd_a;
   logic [7:0] internal_data_ram_rd_b;
   logic       internal_data_ram_we;
   logic [7:0] internal_data_ram_wa;
   logic [7:0] internal_data_ram_wd;
   logic [7:0] local_rd;
   logic [7:0] bit_byte;
   // Only a direct access above 0x7F is an SPECIAL_FUNCTION_REGISTER access
   assign direct_upper = int_req.mode == MODE_DIRECT
                         && int_req.addr[7];
   assign local_sfr    = int_req.addr inside {SFR_PRIM_LO, SFR_PRIM_HI,
                         SFR_SEC_LO, SFR_SEC_HI, SFR_PTR_SEL};
   // Bank operands take their bank from the status word
   assign internal_data_ram_addr_a = (int_req.mode == MODE_BANKREG)
                        ? {3'b000, psw_bank, int_req.addr[2:0]}
                        : int_req.addr;

   // Port b serves bit accesses, otherwise the Ri fetch for external moves
   assign bit_byte    = {BIT_AREA_BASE[7:4], bit_req.bit_addr[6:3]};
   assign internal_data_ram_addr_b = bit_req.valid ? bit_byte
                        : {3'b000, psw_bank, 2'b00, xmove.index_sel};

   // Write port: byte requests win over bit writes
   always_comb begin
      internal_data_ram_we = 1'b0;
      internal_data_ram_wa = internal_data_ram_addr_a;
      internal_data_ram_wd = int_req.wdata;
      if (int_req.valid && int_req.write && !direct_upper) begin
         internal_data_ram_we = 1'b1;
      end else if (bit_req.valid && bit_req.write
                   && !bit_req.bit_addr[7]) begin
         internal_data_ram_we = 1'b1;
         internal_data_ram_wa = bit_byte;
         internal_data_ram_wd = internal_data_ram_rd_b;
         internal_data_ram_wd[bit_req.bit_addr[2:0]] = bit_req.wbit;
      end
   end

   // One flat 256-byte store; upper half is indirect-only RAM
   byte_store #(.DEPTH(INTERNAL_DATA_RAM_BYTES)) internal_data_ram_store (
      .sys_clk   (sys_clk),
      .wr_en     (internal_data_ram_we),
      .wr_addr   (internal_data_ram_wa),
      .wr_data   (internal_data_ram_wd),
      .rd_addr_a (internal_data_ram_addr_a),
      .rd_data_a (internal_data_ram_rd_a),
      .rd_addr_b (internal_data_ram_addr_b),
      .rd_data_b (internal_data_ram_rd_b)
   );

   // Read mux for the locally held SFRs; reserved bits read zero
   always_comb begin
      local_rd = 8'h00;
      case (int_req.addr)
         SFR_PRIM_LO: local_rd = primary_data_pointer[7:0];
         SFR_PRIM_HI: local_rd = primary_data_pointer[15:8];
         SFR_SEC_LO:  local_rd = secondary_data_pointer[7:0];
         SFR_SEC_HI:  local_rd = secondary_data_pointer[15:8];
         SFR_PTR_SEL: local_rd[PTR_SEL_BIT] = pointer_select;
         default:     local_rd = 8'h00;
      endcase
   end

   // Other SFRs live outside; forward direct upper accesses only
   assign sfr_req = '{valid: int_req.valid && direct_upper && !local_sfr,
                      write: int_req.write, addr: {8'h00, int_req.addr},
                      wdata: int_req.wdata};

   // ********************************************************************
   // External address decode
   // ********************************************************************
   logic [15:0] xaddr;
   logic        external_data_ram_hit;
   logic        periph_hit;
   logic [7:0]  external_data_ram_rd;
   assign xaddr      = xmove.use_pointer ? active_pointer
                       : {8'h00, internal_data_ram_rd_b};
   assign external_data_ram_hit   = xaddr <= EXTERNAL_DATA_RAM_TOP;
   assign periph_hit = xaddr >= PERIPH_BASE;

   assign periph_req = '{valid: xmove.valid && periph_hit,
                         write: xmove.write, addr: xaddr,
                         wdata: xmove.wdata};

   byte_store #(.DEPTH(EXTERNAL_DATA_RAM_DEPTH)) external_data_ram_store (
      .sys_clk   (sys_clk),
      .wr_en     (xmove.valid && xmove.write && external_data_ram_hit),
      .wr_addr   (xaddr[XAW-1:0]),
      .wr_data   (xmove.wdata),
      .rd_addr_a (xaddr[XAW-1:0]),
      .rd_data_a (external_data_ram_rd),
      .rd_addr_b (xaddr[XAW-1:0]),
      .rd_data_b ()
   );

   // ********************************************************************
   // Read answers, one cycle after the request
   // ********************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         int_rdata  <= RDATA_RESET;
         int_rvalid <= 1'b0;
      end else begin
         int_rvalid <= int_req.valid && !int_req.write;
         if (int_req.valid && !int_req.write) begin
            int_rdata <= !direct_upper ? internal_data_ram_rd_a
                         : local_sfr ? local_rd : sfr_rdata;
         end
      end
   end

   // Bit reads above 0x7F belong to SPECIAL_FUNCTION_REGISTER logic elsewhere and read zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bit_rdata  <= 1'b0;
         bit_rvalid <= 1'b0;
      end else begin
         bit_rvalid <= bit_req.valid && !bit_req.write;
         if (bit_req.valid && !bit_req.write) begin
            bit_rdata <= !bit_req.bit_addr[7]
                         && internal_data_ram_rd_b[bit_req.bit_addr[2:0]];
         end
      end
   end

   // Unpopulated external addresses read as zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         x_rdata  <= RDATA_RESET;
         x_rvalid <= 1'b0;
      end else begin
         x_rvalid <= xmove.valid && !xmove.write;
         if (xmove.valid && !xmove.write) begin
            x_rdata <= external_data_ram_hit ? external_data_ram_rd
                       : periph_hit ? periph_rdata : 8'h00;
         end
      end
   end

   // ********************************************************************
   // Pointer registers
   // ********************************************************************
   logic sfr_wr;
   assign sfr_wr = int_req.valid && int_req.write && direct_upper;
   // A pointer command in the same cycle as a byte write wins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         primary_data_pointer   <= PTR_RESET;
         secondary_data_pointer <= PTR_RESET;
      end else if (ptr_cmd.op != PTR_NONE) begin
         if (pointer_select) begin
            secondary_data_pointer <= (ptr_cmd.op == PTR_LOAD)
               ? ptr_cmd.value : secondary_data_pointer + 16'h0001;
         end else begin
            primary_data_pointer <= (ptr_cmd.op == PTR_LOAD)
               ? ptr_cmd.value : primary_data_pointer + 16'h0001;
         end
      end else if (sfr_wr) begin
         case (int_req.addr)
            SFR_PRIM_LO: primary_data_pointer[7:0]    <= int_req.wdata;
            SFR_PRIM_HI: primary_data_pointer[15:8]   <= int_req.wdata;
            SFR_SEC_LO:  secondary_data_pointer[7:0]  <= int_req.wdata;
            SFR_SEC_HI:  secondary_data_pointer[15:8] <= int_req.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pointer_select <= PTR_SEL_RESET;
      end else if (sfr_wr && int_req.addr == SFR_PTR_SEL) begin
         pointer_select <= int_req.wdata[PTR_SEL_BIT];
      end
   end

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_sfr_direct_only: assert property (
      int_req.valid && int_req.mode != MODE_DIRECT |-> !sfr_req.valid)
      else $error("SPECIAL_FUNCTION_REGISTER reached by non-direct access");
   a_upper_indirect_ram: assert property (
      int_req.valid && int_req.write && int_req.mode == MODE_INDIRECT
      |-> internal_data_ram_we && internal_data_ram_wa == int_req.addr)
      else $error("Indirect upper write missed RAM");
   a_bank_map: assert property (
      int_req.valid && int_req.mode == MODE_BANKREG
      |-> internal_data_ram_addr_a == 8 * psw_bank + int_req.addr[2:0])
      else $error("Bank register mapped wrong");
   a_lower_read_back: assert property (
      int_req.valid && int_req.write && int_req.mode == MODE_DIRECT
      && !int_req.addr[7] ##1 int_req.valid && !int_req.write
      && int_req.mode == MODE_INDIRECT && int_req.addr == $past(int_req.addr)
      |=> int_rvalid && int_rdata == $past(int_req.wdata, 2))
      else $error("Lower byte differs between modes");
   a_ri_width: assert property (
      xmove.valid && !xmove.use_pointer |-> xaddr[15:8] == 8'h00)
      else $error("Index form address above 8 bits");
   a_pointer_addr: assert property (
      xmove.valid && xmove.use_pointer |-> xaddr ==
      (pointer_select ? secondary_data_pointer : primary_data_pointer))
      else $error("Pointer form uses wrong pointer");
   a_inc_selected: assert property (
      ptr_cmd.op == PTR_INC && !pointer_select |=>
      primary_data_pointer == $past(primary_data_pointer) + 16'h0001
      && $stable(secondary_data_pointer))
      else $error("Increment hit unselected pointer");
   a_select_write: assert property (
      sfr_wr && int_req.addr == SFR_PTR_SEL
      |=> pointer_select == $past(int_req.wdata[0]))
      else $error("Pointer select not updated");
   a_hole_empty: assert property (
      xmove.valid && !xmove.write && !external_data_ram_hit && !periph_hit
      |=> x_rvalid && x_rdata == 8'h00)
      else $error("Unpopulated address returned data");
   a_read_latency: assert property (
      xmove.valid && !xmove.write |=> x_rvalid)
      else $error("External read answer late");
   c_bank_three: cover property (int_req.valid && psw_bank == 2'd3
      && int_req.mode == MODE_BANKREG);
   c_secondary_move: cover property (pointer_select && xmove.valid
      && xmove.use_pointer && external_data_ram_hit);
   c_periph_read: cover property (periph_req.valid && !periph_req.write);
   c_bit_write: cover property (bit_req.valid && bit_req.write);

endmodule

// ### shared/mem_map_pkg.sv
/*
 * Constants and carrier types for the data memory address map block.
 * Assumes one core clock and a core that issues at most one internal,
 * one bit and one external request per cycle on separate ports.
 */
package mem_map_pkg;

   // ********************************************************************
   // Internal data space
   // ********************************************************************
   localparam int           INTERNAL_DATA_RAM_BYTES     = 256;
   localparam logic [7:0]   UPPER_BASE     = 8'h80;
   localparam logic [7:0]   BIT_AREA_BASE  = 8'h20;
   localparam int           BANK_REGS      = 8;

   // Locally held special function registers (direct access only)
   localparam logic [7:0]   SFR_PRIM_LO    = 8'h82;
   localparam logic [7:0]   SFR_PRIM_HI    = 8'h83;
   localparam logic [7:0]   SFR_SEC_LO     = 8'h84;
   localparam logic [7:0]   SFR_SEC_HI     = 8'h85;
   localparam logic [7:0]   SFR_PTR_SEL    = 8'h86;
   localparam int           PTR_SEL_BIT    = 0;

   // ********************************************************************
   // External data space
   // ********************************************************************
   localparam int           EXTERNAL_DATA_RAM_BYTES     = 2048;
   localparam logic [15:0]  EXTERNAL_DATA_RAM_TOP       = 16'h07FF;
   localparam logic [15:0]  PERIPH_BASE    = 16'hFC00;

   // Reset values
   localparam logic [15:0]  PTR_RESET      = 16'h0000;
   localparam logic         PTR_SEL_RESET  = 1'b0;
   localparam logic [7:0]   RDATA_RESET    = 8'h00;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {MODE_DIRECT, MODE_INDIRECT, MODE_BANKREG}
      addr_mode_t;

   typedef enum logic [1:0] {PTR_NONE, PTR_LOAD, PTR_INC} ptr_op_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      addr_mode_t  mode;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } int_req_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  bit_addr;
      logic        wbit;
   } bit_req_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        use_pointer;
      logic        index_sel;
      logic [7:0]  wdata;
   } xmove_req_t;

   typedef struct packed {
      ptr_op_t     op;
      logic [15:0] value;
   } ptr_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bus_req_t;

endpackage

// ### sim/far_side_model.sv
/*
 * Far side of a forwarded bus: SPECIAL_FUNCTION_REGISTER or peripheral register block.
 * Assumes requests arrive from the design on sys_clk and that the
 * answer to a read is wanted in the same cycle.
 */
`timescale 1ns/1ps

module far_side_model
   import mem_map_pkg::*;
(
   input  wire logic     sys_clk,
   input  wire bus_req_t req,
   output logic [7:0]    rdata
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [7:0] regs [256];
   logic [7:0] noise;

   // Preset so untouched places read a pattern the bench can predict
   initial begin
      for (int i = 0; i < 256; i++) begin
         regs[i] = 8'hA5 ^ 8'(i);
      end
      noise = 8'h3C;
   end

   // Writes land at the edge; the idle pattern moves every cycle
   always @(posedge sys_clk) begin
      noise <= ~noise + 8'h01;
      if (req.valid && req.write) begin
         regs[req.addr[7:0]] <= req.wdata;
      end
   end

   // Idle answer alternates between 0x3C and 0xC4 rather than holding the last data
   assign rdata = (req.valid && !req.write) ? regs[req.addr[7:0]] : noise;
endmodule

// ### sim/tb_data_memory_map.sv
/*
 * Self-checking bench for the data memory map block.
 * Assumes the package constants and two far side register models.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("BAD %s exp %h got %h", nm, (e), (g)); end end

module tb_data_memory_map
   import mem_map_pkg::*;
;
   logic        sys_clk, rst, int_rvalid, bit_rdata, bit_rvalid, x_rvalid;
   logic        seen_sfr, seen_per;
   logic [1:0]  psw_bank;
   logic [7:0]  int_rdata, x_rdata, sfr_rdata, periph_rdata, a, d, q;
   logic [15:0] active_pointer, p;
   int_req_t    int_req;
   bit_req_t    bit_req;
   xmove_req_t  xmove;
   ptr_cmd_t    ptr_cmd;
   bus_req_t    sfr_req, periph_req;
   int          n, k, b, fail_count, total_checks;

   data_memory_map DUT (
      .sys_clk(sys_clk), .rst(rst), .psw_bank(psw_bank),
      .int_req(int_req), .int_rdata(int_rdata), .int_rvalid(int_rvalid),
      .bit_req(bit_req), .bit_rdata(bit_rdata), .bit_rvalid(bit_rvalid),
      .xmove(xmove), .x_rdata(x_rdata), .x_rvalid(x_rvalid),
      .ptr_cmd(ptr_cmd), .active_pointer(active_pointer),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .periph_req(periph_req), .periph_rdata(periph_rdata)
   );
   far_side_model sfr_side (.sys_clk(sys_clk), .req(sfr_req),
      .rdata(sfr_rdata));
   far_side_model per_side (.sys_clk(sys_clk), .req(periph_req),
      .rdata(periph_rdata));

   // ****************************************************************
   // Drivers
   // ****************************************************************
   // Every request port is set once per step, so no request lingers between ops
   task automatic step(input int_req_t ir, input bit_req_t br,
                       input xmove_req_t xr, input ptr_cmd_t pc);
      int_req = ir;
      bit_req = br;
      xmove = xr;
      ptr_cmd = pc;
      #1 seen_sfr = sfr_req.valid;
      seen_per = periph_req.valid;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic iop(input logic w, input addr_mode_t m,
                      input logic [7:0] ad, input logic [7:0] dd);
      step('{1'b1, w, m, ad, dd}, '0, '0, '0);
      if (!w) begin
         `CHK("int_rvalid", 1'b1, int_rvalid)
         q = int_rdata;
      end
   endtask

   task automatic xop(input logic w, input logic up, input logic ix,
                      input logic [7:0] dd);
      step('0, '0, '{1'b1, w, up, ix, dd}, '0);
      if (!w) begin
         `CHK("x_rvalid", 1'b1, x_rvalid)
         q = x_rdata;
      end
   endtask

   task automatic bop(input logic w, input logic [7:0] ba, input logic wb);
      step('0, '{1'b1, w, ba, wb}, '0, '0);
      if (!w) begin
         `CHK("bit_rvalid", 1'b1, bit_rvalid)
      end
   endtask

   task automatic pop(input ptr_op_t o, input logic [15:0] v);
      step('0, '0, '0, '{o, v});
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Hang guard: a run this long can only mean a stuck sequence
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      test_done();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      fail_count = 0;
      total_checks = 0;
      rst = 1'b1;
      psw_bank = 2'h0;
      int_req = '0;
      bit_req = '0;
      xmove = '0;
      ptr_cmd = '0;
      void'($urandom(32'h29BD95A4));
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      `CHK("ptr_reset", PTR_RESET, active_pointer)
      // Lower half: direct and indirect reach the same bytes
      for (n = 0; n < 8; n++) begin
         a = (n == 0) ? 8'h7F : 8'($urandom_range(0, 127));
         d = 8'($urandom);
         iop(1'b1, MODE_DIRECT, a, d);
         iop(1'b0, MODE_INDIRECT, a, 8'h00);
         `CHK("low_ind", d, q)
         iop(1'b1, MODE_INDIRECT, a, ~d);
         iop(1'b0, MODE_DIRECT, a, 8'h00);
         `CHK("low_dir", ~d, q)
      end
      $display("test lower done");
      // Upper half: indirect is RAM, direct goes out as SPECIAL_FUNCTION_REGISTER access
      for (n = 0; n < 6; n++) begin
         a = (n == 0) ? 8'h80 : (n == 1) ? 8'hFF
             : 8'($urandom_range(144, 255));
         d = 8'($urandom);
         iop(1'b1, MODE_INDIRECT, a, d);
         `CHK("ind_no_sfr", 1'b0, seen_sfr)
         iop(1'b1, MODE_DIRECT, a, ~d);
         `CHK("dir_sfr_wr", 1'b1, seen_sfr)
         iop(1'b0, MODE_DIRECT, a, 8'h00);
         `CHK("dir_sfr_req", 1'b1, seen_sfr)
         `CHK("dir_sfr_data", ~d, q)
         iop(1'b0, MODE_INDIRECT, a, 8'h00);
         `CHK("upper_ram", d, q)
      end
      $display("test upper done");
      for (n = 0; n < 4; n++) begin
         psw_bank = 2'(n);
         k = $urandom_range(0, 7);
         d = 8'($urandom);
         iop(1'b1, MODE_BANKREG, 8'(k), d);
         iop(1'b0, MODE_DIRECT, 8'(8 * n + k), 8'h00);
         `CHK("bank_reg", d, q)
      end
      $display("test banks done");
      for (n = 0; n < 6; n++) begin
         k = (n == 0) ? 0 : (n == 1) ? 127 : $urandom_range(0, 127);
         a = 8'(32 + k / 8);
         d = 8'($urandom);
         iop(1'b1, MODE_DIRECT, a, d);
         bop(1'b1, 8'(k), ~d[k % 8]);
         bop(1'b0, 8'(k), 1'b0);
         `CHK("bit_read", ~d[k % 8], bit_rdata)
         d[k % 8] = ~d[k % 8];
         iop(1'b0, MODE_DIRECT, a, 8'h00);
         `CHK("bit_byte", d, q)
      end
      // Bit addresses above 0x7F must not reach the bit area bytes
      bop(1'b1, 8'h80 | 8'(k), ~d[k % 8]);
      bop(1'b0, 8'(k), 1'b0);
      `CHK("bit_upper_wr", d[k % 8], bit_rdata)
      bop(1'b0, 8'h80 | 8'(k), 1'b0);
      `CHK("bit_upper_rd", 1'b0, bit_rdata)
      $display("test bits done");
      p = 16'($urandom);
      pop(PTR_LOAD, p);
      `CHK("prim_load", p, active_pointer)
      iop(1'b1, MODE_DIRECT, SFR_PTR_SEL, 8'h01);
      `CHK("sel_sec", PTR_RESET, active_pointer)
      pop(PTR_LOAD, ~p);
      pop(PTR_INC, 16'h0000);
      `CHK("sec_inc", ~p + 16'h0001, active_pointer)
      iop(1'b0, MODE_DIRECT, SFR_SEC_LO, 8'h00);
      `CHK("sec_lo", 8'(~p + 16'h0001), q)
      iop(1'b1, MODE_DIRECT, SFR_PTR_SEL, 8'h00);
      `CHK("sel_prim", p, active_pointer)
      // Mid-run reset with the secondary selected and a read answer up
      iop(1'b1, MODE_DIRECT, SFR_PTR_SEL, 8'h01);
      iop(1'b0, MODE_DIRECT, SFR_PRIM_LO, 8'h00);
      `CHK("prim_lo", p[7:0], q)
      int_req = '0;
      rst = 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      `CHK("rst_rvalid", 1'b0, int_rvalid)
      `CHK("rst_ptr", PTR_RESET, active_pointer)
      iop(1'b0, MODE_DIRECT, SFR_PTR_SEL, 8'h00);
      `CHK("rst_sel", 8'h00, q)
      $display("test pointers done");
      // External RAM by pointer, then by index register
      for (n = 0; n < 6; n++) begin
         p = (n == 0) ? 16'h0000 : (n == 1) ? EXTERNAL_DATA_RAM_TOP
             : 16'($urandom_range(0, 2047));
         d = 8'($urandom);
         pop(PTR_LOAD, p);
         xop(1'b1, 1'b1, 1'b0, d);
         xop(1'b0, 1'b1, 1'b0, 8'h00);
         `CHK("external_data_ram_ptr", d, q)
         b = $urandom_range(0, 3);
         k = $urandom_range(0, 1);
         psw_bank = 2'(b);
         iop(1'b1, MODE_DIRECT, 8'(8 * b + k), p[7:0]);
         xop(1'b1, 1'b0, 1'(k), ~d);
         pop(PTR_LOAD, {8'h00, p[7:0]});
         xop(1'b0, 1'b1, 1'b0, 8'h00);
         `CHK("external_data_ram_ri", ~d, q)
      end
      $display("test external_data_ram done");
      // Unpopulated hole holds nothing; top 1KB is forwarded
      for (n = 0; n < 4; n++) begin
         p = (n == 0) ? 16'h0800 : (n == 1) ? 16'hFBFF
             : 16'($urandom_range(2048, 64511));
         pop(PTR_LOAD, p);
         xop(1'b1, 1'b1, 1'b0, 8'h5A);
         `CHK("hole_no_per", 1'b0, seen_per)
         xop(1'b0, 1'b1, 1'b0, 8'h00);
         `CHK("hole_read", 8'h00, q)
         k = (n == 0) ? 0 : (n == 1) ? 1023 : $urandom_range(0, 1023);
         d = 8'($urandom);
         pop(PTR_LOAD, PERIPH_BASE + 16'(k));
         xop(1'b1, 1'b1, 1'b0, d);
         `CHK("per_wr", 1'b1, seen_per)
         xop(1'b0, 1'b1, 1'b0, 8'h00);
         `CHK("per_req", 1'b1, seen_per)
         `CHK("per_read", d, q)
      end
      $display("test external map done");
      test_done();
   end
endmodule
